// ---- common/word_port_defs.vh ----
// Purpose: Shared constants for the parallel word port control block.
// Assumes: AXI4-Lite register access with 32-bit data, byte addresses.
// Notes: Offsets are byte addresses of aligned words.
`ifndef WORD_PORT_DEFS_VH
`define WORD_PORT_DEFS_VH
`define CTRL_OFFSET 8'h00
`define STATUS_OFFSET 8'h04
`define TXWORD_OFFSET 8'h08
`define RXWORD_OFFSET 8'h0C
`define CTRL_BIT_ORDER 0
`define CTRL_SQUELCH_N 1
`define CTRL_LOOPBACK_N 2
`define CTRL_SLICE_MODE 3
`define CTRL_WIDTH16 4
`define CTRL_REF_SEL 5
`define CTRL_RESET 32'h0000_0036
`define STAT_TX_VALID 0
`define STAT_TX_OVERRUN 1
`define STAT_REF_FROM_WORDCLK 2
`define STAT_SLICE_PROP 3
`define AXI_RESP_OKAY 2'h0
`define AXI_RESP_DECERR 2'h3
`endif

// ---- hdl/word_buffer.v ----
// Purpose: Two-entry valid/ready buffer in the word path.
// Assumes: Single clock, synchronous active-low reset.
// Notes: Depth is fixed at two so a short stall loses no word.
`timescale 1ns/1ps
module word_buffer #(
   parameter WIDTH = 16
) (
   input wire aclk, // Clock.
   input wire aresetn, // Synchronous reset, active low.
   input wire in_valid, // Word offered.
   output wire in_ready, // Space available.
   input wire [WIDTH-1:0] in_data, // Word in.
   output wire out_valid, // Word available.
   input wire out_ready, // Drain accepts.
   output wire [WIDTH-1:0] out_data // Word out.
);
   reg [WIDTH-1:0] mem_r [0:1];
   reg wr_ptr_r;
   reg rd_ptr_r;
   reg [1:0] count_r;
   wire push;
   wire pop;
   assign in_ready = (count_r != 2'h2);
   assign out_valid = (count_r != 2'h0);
   assign out_data = mem_r[rd_ptr_r];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   always @(posedge aclk) begin
      if (!aresetn) begin
         wr_ptr_r <= 1'b0;
         rd_ptr_r <= 1'b0;
         count_r <= 2'h0;
      end else begin
         if (push) begin
            wr_ptr_r <= ~wr_ptr_r;
         end
         if (pop) begin
            rd_ptr_r <= ~rd_ptr_r;
         end
         if (push && !pop) begin
            count_r <= count_r + 2'h1;
         end else if (pop && !push) begin
            count_r <= count_r - 2'h1;
         end
      end
   end
   always @(posedge aclk) begin
      if (push) begin
         mem_r[wr_ptr_r] <= in_data;
      end
   end
endmodule

// ---- hdl/bit_sync.v ----
// Purpose: Two-flop synchroniser for levels from outside the clock domain.
// Assumes: Inputs change slowly relative to aclk.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ps
module bit_sync #(
   parameter WIDTH = 1
) (
   input wire aclk, // Clock.
   input wire aresetn, // Synchronous reset, active low.
   input wire [WIDTH-1:0] d, // Asynchronous input.
   output reg [WIDTH-1:0] q // Synchronised output.
);
   reg [WIDTH-1:0] meta_r;
   always @(posedge aclk) begin
      if (!aresetn) begin
         meta_r <= {WIDTH{1'b0}};
         q <= {WIDTH{1'b0}};
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule

// ---- hdl/word_port_ctrl.v ----
// Purpose: Parallel word side control: receive bit order and squelch, transmit capture.
// Assumes: AXI4-Lite slave on aclk; the word clock and transmit word arrive asynchronously.
// Notes: Word clock edges are found by oversampling, so it must run well below aclk/2.
//
// Our own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "word_port_defs.vh"
// Overview of operation
// R1 - Order select low: first serial bit lands on lane 0, ascending.
// R2 - Order select high: first serial bit lands on top lane, descending.
// R3 - Squelch low forces the whole receive word to zero.
// R4 - Squelch is ignored while diagnostic loopback is active (low).
// R5 - Squelch resets high, so output is unsquelched by default.
// R6 - Slice mode 0 selects absolute, 1 selects proportional adjustment.
// R7 - Transmit word is sampled on the rising edge of the word clock.
// R8 - Reference select low uses the word clock as reference clock.
// R9 - Width select picks 4-bit or 16-bit words on both buses.
// R10 - Squelch applies to whole words, never partially zeroed words.
module word_port_ctrl #(
   parameter WIDTH = 16
) (
   input wire aclk, // Clock, 100 MHz.
   input wire aresetn, // Synchronous reset, active low.
   input wire [7:0] s_axi_awaddr, // Write address.
   input wire s_axi_awvalid, // Write address valid.
   output reg s_axi_awready, // Write address ready.
   input wire [31:0] s_axi_wdata, // Write data.
   input wire [3:0] s_axi_wstrb, // Write strobes.
   input wire s_axi_wvalid, // Write data valid.
   output reg s_axi_wready, // Write data ready.
   output reg [1:0] s_axi_bresp, // Write response.
   output reg s_axi_bvalid, // Write response valid.
   input wire s_axi_bready, // Write response ready.
   input wire [7:0] s_axi_araddr, // Read address.
   input wire s_axi_arvalid, // Read address valid.
   output reg s_axi_arready, // Read address ready.
   output reg [31:0] s_axi_rdata, // Read data.
   output reg [1:0] s_axi_rresp, // Read response.
   output reg s_axi_rvalid, // Read data valid.
   input wire s_axi_rready, // Read data ready.
   input wire rx_bit_valid, // Recovered serial bit strobe, same clock.
   input wire rx_bit, // Recovered serial bit, same clock.
   output reg [WIDTH-1:0] rx_word_out, // Parallel receive word.
   output reg rx_word_valid, // Pulse when rx_word_out updates.
   input wire tx_word_clock_in, // Framer word clock, asynchronous.
   input wire [WIDTH-1:0] tx_word_in, // Framer transmit word, asynchronous.
   output reg [WIDTH-1:0] tx_word_out, // Captured word toward serializer.
   output reg tx_word_valid, // Word held for serializer.
   input wire tx_word_ready, // Serializer takes word.
   output reg ref_from_word_clock, // Reference taken from word clock.
   output reg slice_proportional // Slice adjustment mode.
);
   localparam [4:0] BITS_WIDE = 5'h10;
   localparam [4:0] BITS_NARROW = 5'h04;
   reg [31:0] ctrl_r;
   reg tx_overrun_r;
   reg [WIDTH-1:0] shift_r;
   reg [4:0] bit_cnt_r;
   reg clk_prev_r;
   reg [WIDTH-1:0] tx_data_r;
   reg capture_r;
   reg aw_held_r;
   reg w_held_r;
   reg [7:0] awaddr_r;
   reg [31:0] wdata_r;
   reg [3:0] wstrb_r;
   wire [WIDTH:0] sync_q;
   wire wclk_s;
   wire [WIDTH-1:0] tx_in_s;
   wire buf_in_ready;
   wire buf_out_valid;
   wire [WIDTH-1:0] buf_out_data;
   wire width16;
   wire [4:0] word_bits;
   wire squelch_active;
   wire [WIDTH-1:0] shift_nxt;
   wire [WIDTH-1:0] rx_word_nxt;
   wire [31:0] ctrl_nxt;
   wire [31:0] status;
   wire wr_fire;
   integer i;

   function [31:0] merge_strb;
      input [31:0] old;
      input [31:0] data;
      input [3:0] strb;
      integer k;
      begin
         merge_strb = old;
         for (k = 0; k < 4; k = k + 1) begin
            if (strb[k]) begin
               merge_strb[k*8 +: 8] = data[k*8 +: 8];
            end
         end
      end
   endfunction

   // Only the four aligned words answer; any other address gets a decode error.
   function addr_mapped;
      input [7:0] a;
      begin
         if (a == `CTRL_OFFSET || a == `STATUS_OFFSET) begin
            addr_mapped = 1'b1;
         end else if (a == `TXWORD_OFFSET || a == `RXWORD_OFFSET) begin
            addr_mapped = 1'b1;
         end else begin
            addr_mapped = 1'b0;
         end
      end
   endfunction

   // Clock and word travel through two flops together; the word is read from the same sample that shows the edge.
   bit_sync #(.WIDTH(WIDTH + 1)) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .d({tx_word_clock_in, tx_word_in}),
      .q(sync_q)
   );
   assign wclk_s = sync_q[WIDTH];
   assign tx_in_s = sync_q[WIDTH-1:0];

   assign width16 = ctrl_r[`CTRL_WIDTH16];
   assign word_bits = width16 ? BITS_WIDE : BITS_NARROW; // R9
   // Loopback low overrides squelch.
   assign squelch_active = !ctrl_r[`CTRL_SQUELCH_N] && ctrl_r[`CTRL_LOOPBACK_N]; // R3 R4

   // Shifting toward the top puts the first bit on the top active lane; toward lane 0 puts it on lane 0 at 16-bit width, lane WIDTH-4 at 4-bit width.
   assign shift_nxt = ctrl_r[`CTRL_BIT_ORDER] ?
      {shift_r[WIDTH-2:0], rx_bit} : // R2
      {rx_bit, shift_r[WIDTH-1:1]}; // R1

   // Low order with 4-bit width: the first bit sits in lane WIDTH-4 and must move down to lane 0.
   genvar g;
   generate
      for (g = 0; g < WIDTH; g = g + 1) begin : g_lane
         if (g < 4) begin : g_low
            assign rx_word_nxt[g] = squelch_active ? 1'b0 :
               (!width16 && !ctrl_r[`CTRL_BIT_ORDER]) ? shift_nxt[WIDTH-4+g] : shift_nxt[g]; // R1 R2 R3
         end else begin : g_high
            assign rx_word_nxt[g] = (squelch_active || !width16) ? 1'b0 : shift_nxt[g]; // R3 R9
         end
      end
   endgenerate

   // The bit counter is not cleared on a width change; a drop to 4-bit width with the count above 3 runs it to 31 and wraps before a word completes.
   always @(posedge aclk) begin
      if (!aresetn) begin
         shift_r <= {WIDTH{1'b0}};
         bit_cnt_r <= 5'h00;
         rx_word_out <= {WIDTH{1'b0}};
         rx_word_valid <= 1'b0;
      end else begin
         rx_word_valid <= 1'b0;
         if (rx_bit_valid) begin
            shift_r <= shift_nxt;
            if (bit_cnt_r == word_bits - 5'h01) begin
               bit_cnt_r <= 5'h00;
               // Squelch is sampled once per completed word.
               rx_word_out <= rx_word_nxt; // R10
               rx_word_valid <= 1'b1;
            end else begin
               bit_cnt_r <= bit_cnt_r + 5'h01;
            end
         end
      end
   end

   // Transmit capture on rising word clock edges, buffered toward the serializer.
   always @(posedge aclk) begin
      if (!aresetn) begin
         clk_prev_r <= 1'b0;
         capture_r <= 1'b0;
         tx_data_r <= {WIDTH{1'b0}};
         tx_overrun_r <= 1'b0;
      end else begin
         clk_prev_r <= wclk_s;
         capture_r <= 1'b0;
         if (wclk_s && !clk_prev_r) begin
            tx_data_r <= width16 ? tx_in_s : {{(WIDTH-4){1'b0}}, tx_in_s[3:0]}; // R7 R9
            capture_r <= 1'b1;
         end
         // A word arriving with the buffer full is lost and flagged; the flag sets over a clear.
         if (capture_r && !buf_in_ready) begin
            tx_overrun_r <= 1'b1;
         end else if (wr_fire && awaddr_r == `STATUS_OFFSET && wdata_r[`STAT_TX_OVERRUN]) begin
            tx_overrun_r <= 1'b0;
         end
      end
   end

   // The buffer sits between capture and the output stage so a short serializer stall costs no word.
   word_buffer #(.WIDTH(WIDTH)) u_buf (
      .aclk(aclk),
      .aresetn(aresetn),
      .in_valid(capture_r),
      .in_ready(buf_in_ready),
      .in_data(tx_data_r),
      .out_valid(buf_out_valid),
      .out_ready(!tx_word_valid || tx_word_ready),
      .out_data(buf_out_data)
   );

   // Holding the word here keeps the output a plain flop while the buffer absorbs the stall.
   always @(posedge aclk) begin
      if (!aresetn) begin
         tx_word_out <= {WIDTH{1'b0}};
         tx_word_valid <= 1'b0;
         ref_from_word_clock <= 1'b0;
         slice_proportional <= 1'b0;
      end else begin
         if (!tx_word_valid || tx_word_ready) begin
            tx_word_valid <= buf_out_valid;
            if (buf_out_valid) begin
               tx_word_out <= buf_out_data;
            end
         end
         ref_from_word_clock <= !ctrl_r[`CTRL_REF_SEL]; // R8
         slice_proportional <= ctrl_r[`CTRL_SLICE_MODE]; // R6
      end
   end

   // AXI4-Lite write: address and data taken in either order, response after both.
   // Readies pulse every other cycle while idle, so a master must hold valid until it sees ready.
   assign wr_fire = aw_held_r && w_held_r && !s_axi_bvalid;
   assign ctrl_nxt = merge_strb(ctrl_r, wdata_r, wstrb_r) & 32'h0000_003F;

   always @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_r <= `CTRL_RESET; // R5
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         awaddr_r <= 8'h00;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `AXI_RESP_OKAY;
      end else begin
         s_axi_awready <= !aw_held_r && !s_axi_awready && !s_axi_bvalid;
         s_axi_wready <= !w_held_r && !s_axi_wready && !s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wr_fire) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (awaddr_r == `CTRL_OFFSET) begin
               ctrl_r <= ctrl_nxt;
               s_axi_bresp <= `AXI_RESP_OKAY;
            end else if (addr_mapped(awaddr_r)) begin
               s_axi_bresp <= `AXI_RESP_OKAY;
            end else begin
               s_axi_bresp <= `AXI_RESP_DECERR;
            end
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   assign status = {28'h0000000, slice_proportional, ref_from_word_clock, tx_overrun_r, tx_word_valid};

   // Read data follows one cycle after the address is taken; a new address waits for the data to go.
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `AXI_RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `AXI_RESP_OKAY;
            s_axi_rdata <= 32'h0000_0000;
            if (s_axi_araddr == `CTRL_OFFSET) begin
               s_axi_rdata <= ctrl_r;
            end else if (s_axi_araddr == `STATUS_OFFSET) begin
               s_axi_rdata <= status;
            end else if (s_axi_araddr == `TXWORD_OFFSET) begin
               for (i = 0; i < WIDTH; i = i + 1) begin
                  s_axi_rdata[i] <= tx_word_out[i];
               end
            end else if (s_axi_araddr == `RXWORD_OFFSET) begin
               for (i = 0; i < WIDTH; i = i + 1) begin
                  s_axi_rdata[i] <= rx_word_out[i];
               end
            end else if (!addr_mapped(s_axi_araddr)) begin
               s_axi_rresp <= `AXI_RESP_DECERR;
            end
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule

// ---- dv/wpc_assertions.sv ----
// Purpose: Port-level checks for the parallel word port control block.
// Assumes: Single aclk domain, synchronous active-low reset.
// Notes: Control bits live in CTRL, so checks tie outputs to port causes.
`timescale 1ns/1ps
module wpc_assertions #(
   parameter WIDTH = 16
) (
   input wire aclk, // Clock.
   input wire aresetn, // Reset, active low.
   input wire s_axi_bvalid, // Write response valid.
   input wire s_axi_bready, // Write response ready.
   input wire [1:0] s_axi_bresp, // Write response.
   input wire s_axi_rvalid, // Read data valid.
   input wire s_axi_rready, // Read data ready.
   input wire [31:0] s_axi_rdata, // Read data.
   input wire rx_bit_valid, // Bit strobe.
   input wire [WIDTH-1:0] rx_word_out, // Receive word.
   input wire rx_word_valid, // Receive word pulse.
   input wire tx_word_clock_in, // Word clock.
   input wire [WIDTH-1:0] tx_word_out, // Captured word.
   input wire tx_word_valid, // Captured word valid.
   input wire tx_word_ready, // Serializer accepts.
   input wire ref_from_word_clock, // Reference select.
   input wire slice_proportional // Slice mode.
);
default clocking cb @(posedge aclk); endclocking
default disable iff (!aresetn);
a_bresp_hold:
   assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
a_rdata_hold:
   assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
a_tx_word_hold:
   assert property (tx_word_valid && !tx_word_ready |=> tx_word_valid && $stable(tx_word_out)) else $error("tx word lost");
a_tx_capture_time:
   assert property ($rose(tx_word_clock_in) |-> ##[2:8] tx_word_valid) else $error("tx capture missing");
a_rx_word_gap:
   assert property (rx_word_valid |=> !rx_word_valid [*3]) else $error("rx word shorter than four bits");
a_rx_word_cause:
   assert property (rx_word_valid |-> $past(rx_bit_valid)) else $error("rx word without a bit");
a_rx_whole_word:
   assert property ($changed(rx_word_out) |-> rx_word_valid) else $error("rx word changed between words");
a_mode_by_write:
   assert property ($changed(slice_proportional) || $changed(ref_from_word_clock) |-> $past(s_axi_bvalid) or
      ##[0:3] s_axi_bvalid) else $error("mode output changed without a write");
endmodule
bind word_port_ctrl wpc_assertions #(.WIDTH(WIDTH)) u_chk (.aclk(aclk), .aresetn(aresetn),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
   .rx_bit_valid(rx_bit_valid), .rx_word_out(rx_word_out), .rx_word_valid(rx_word_valid),
   .tx_word_clock_in(tx_word_clock_in), .tx_word_out(tx_word_out), .tx_word_valid(tx_word_valid),
   .tx_word_ready(tx_word_ready), .ref_from_word_clock(ref_from_word_clock),
   .slice_proportional(slice_proportional));

// ---- dv/framer_model.sv ----
// Purpose: Framer side of the transmit word bus.
// Assumes: Word clock of 160 ns, edges 8 ns after a rising aclk edge.
// Notes: The clock stands still between words; the word is inverted after its hold time.
`timescale 1ns/1ps
module framer_model (
   output reg word_clk, // Word clock toward the block.
   output reg [15:0] word // Transmit word.
);
initial begin
   word_clk = 1'b0;
   word = 16'h0000;
end
task send(input [15:0] w);
   begin
      #3;
      word = w;
      // Edges land 8 ns after a rising aclk edge so the synchroniser never races this driver.
      #75 word_clk = 1'b1;
      #80 word_clk = 1'b0;
      word = ~w;
      #2;
   end
endtask
endmodule

// ---- dv/tb_parallel_word_port_control.sv ----
// Purpose: Self-checking bench for the parallel word port control block.
// Assumes: 100 MHz aclk; the framer model makes the word clock.
// Notes: Readiness is raised only after a response shows, so response hold is exercised.
`timescale 1ns/1ps
`include "word_port_defs.vh"
module tb_parallel_word_port_control;
reg aclk = 1'b0;
reg aresetn = 1'b0;
reg [7:0] awaddr = 8'h00, araddr = 8'h00;
reg [31:0] wdata = 32'h0;
reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
reg rx_bit = 1'b0, rx_bit_valid = 1'b0, tx_word_ready = 1'b1;
wire awready, wready, bvalid, arready, rvalid, rx_word_valid, tx_word_valid, ref_o, slice_o, wclk;
wire [1:0] bresp, rresp;
wire [31:0] rdata;
wire [15:0] rx_word_out, tx_word_out, tx_word_in;
integer fail_count = 0, cmp_count = 0, i, k;
reg [15:0] rx_seen, e;
reg [15:0] txq[$];
reg [31:0] rd_d;
reg [1:0] rd_r, wr_r;
reg [7:0] cfg[0:5] = '{8'h16, 8'h17, 8'h06, 8'h07, 8'h14, 8'h10};
always #5 aclk = ~aclk;
word_port_ctrl dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
   .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
   .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
   .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
   .s_axi_rvalid(rvalid), .s_axi_rready(rready), .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit),
   .rx_word_out(rx_word_out), .rx_word_valid(rx_word_valid), .tx_word_clock_in(wclk), .tx_word_in(tx_word_in),
   .tx_word_out(tx_word_out), .tx_word_valid(tx_word_valid), .tx_word_ready(tx_word_ready),
   .ref_from_word_clock(ref_o), .slice_proportional(slice_o));
framer_model fr (.word_clk(wclk), .word(tx_word_in));
always @(posedge aclk) begin
   if (rx_word_valid) rx_seen <= rx_word_out;
   if (tx_word_valid && tx_word_ready) txq.push_back(tx_word_out);
end
task chk(input string nm, input [31:0] got, input [31:0] exp);
   begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
         fail_count = fail_count + 1;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   end
endtask
task wr(input [7:0] a, input [31:0] d);
   begin
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid && !bready) bready <= 1'b1;
      end while (!(bvalid && bready));
      bready <= 1'b0;
      wr_r = bresp;
   end
endtask
task rd(input [7:0] a);
   begin
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         if (rvalid && !rready) rready <= 1'b1;
      end while (!(rvalid && rready));
      rready <= 1'b0;
      rd_d = rdata;
      rd_r = rresp;
   end
endtask
task t_regs;
   begin
      rd(`CTRL_OFFSET);
      chk("ctrl reset", rd_d, `CTRL_RESET);
      chk("ref reset", ref_o, 0);
      chk("slice reset", slice_o, 0);
      rd(8'h10);
      chk("unmapped read", rd_r, `AXI_RESP_DECERR);
      wr(8'h10, 32'h0000_0000);
      chk("unmapped write", wr_r, `AXI_RESP_DECERR);
      $display("test regs done");
   end
endtask
task t_modes;
   begin
      wr(`CTRL_OFFSET, 32'h0000_001E);
      repeat (3) @(posedge aclk);
      chk("slice prop", slice_o, 1);
      chk("ref word clk", ref_o, 1);
      wr(`CTRL_OFFSET, 32'h0000_0036);
      repeat (3) @(posedge aclk);
      chk("slice abs", slice_o, 0);
      chk("ref other", ref_o, 0);
      $display("test modes done");
   end
endtask
task t_rx;
   begin
      for (k = 0; k < 6; k = k + 1) begin
         wr(`CTRL_OFFSET, {24'h0, cfg[k]});
         e = 16'h0000;
         for (i = 0; i < (cfg[k][4] ? 16 : 4); i = i + 1) begin
            @(posedge aclk);
            rx_bit <= 16'hB2C5 >> i;
            rx_bit_valid <= 1'b1;
            e[cfg[k][0] ? (cfg[k][4] ? 15 : 3) - i : i] = 16'hB2C5 >> i;
         end
         @(posedge aclk);
         rx_bit_valid <= 1'b0;
         repeat (3) @(posedge aclk);
         chk("rx word", rx_seen, (cfg[k][2:1] == 2'b10) ? 16'h0000 : e);
      end
      rd(`RXWORD_OFFSET);
      chk("rx word reg", rd_d, 32'h0000_B2C5);
      $display("test rx done");
   end
endtask
task t_tx;
   begin
      wr(`CTRL_OFFSET, 32'h0000_0016);
      fr.send(16'h5A3C);
      wr(`CTRL_OFFSET, 32'h0000_0006);
      fr.send(16'hFFF9);
      repeat (4) @(posedge aclk);
      tx_word_ready <= 1'b0;
      for (i = 1; i < 6; i = i + 1) fr.send(i);
      rd(`STATUS_OFFSET);
      chk("status", rd_d[1:0], 2'b11);
      chk("status modes", rd_d[3:2], 2'b01);
      tx_word_ready <= 1'b1;
      repeat (10) @(posedge aclk);
      chk("tx count", txq.size() >= 4, 1);
      chk("tx word16", txq[0], 16'h5A3C);
      chk("tx word4", txq[1], 16'h0009);
      chk("tx stall first", txq[2], 16'h0001);
      chk("tx stall second", txq[3], 16'h0002);
      wr(`STATUS_OFFSET, 32'h0000_0002);
      rd(`STATUS_OFFSET);
      chk("overrun clear", rd_d[1:0], 2'b00);
      rd(`TXWORD_OFFSET);
      chk("tx word reg", rd_d, 32'h0000_0003);
      $display("test tx done");
   end
endtask
task summarize;
   begin
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   end
endtask
initial begin
   #100000;
   fail_count = fail_count + 1;
   summarize;
end
initial begin
   repeat (20) @(posedge aclk);
   aresetn <= 1'b1;
   t_regs;
   t_modes;
   t_rx;
   t_tx;
   summarize;
end
endmodule
